// file: verilog/oprc_pkg.sv
package oprc_pkg;

   // Register bus geometry.
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register byte addresses, one aligned word each.
   localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_OFFSET = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0c;

   // Control register fields.
   localparam int CTL_CHIP_SLEEP = 0;
   localparam int CTL_FRONT_END_SLEEP = 1;
   localparam int CTL_CONVERTER_SLEEP = 2;
   localparam int CTL_OUTPUT_DRIVE = 3;
   localparam int CTL_FLOOR_CLIP = 4;
   localparam int CTL_BLANK_FORCE = 5;
   localparam int CTL_W = 6;
   localparam logic [CTL_W-1:0] CTL_RESET_VALUE = 6'h38;

   // Reset register and status register fields.
   localparam int RST_BIT = 0;
   localparam int STS_SLEEPING = 0;
   localparam int STS_BUS_DRIVEN = 1;
   localparam int STS_FRONT_END_OFF = 2;
   localparam int STS_CONVERTER_OFF = 3;
   localparam int STS_LEVEL_LSB = 8;

   // Data path widths and reset values.
   localparam int CODE_W = 12;
   localparam int OFFSET_W = 8;
   localparam logic [OFFSET_W-1:0] OFFSET_RESET_VALUE = 8'h00;
   localparam int FIFO_DEPTH = 8;
   localparam int LEVEL_W = $clog2(FIFO_DEPTH + 1);

   // Pin synchroniser lanes and their idle levels.
   localparam int PIN_W = 3;
   localparam int PIN_SLEEP = 0;
   localparam int PIN_OE_N = 1;
   localparam int PIN_PREBLANK = 2;
   localparam logic [PIN_W-1:0] PIN_IDLE = 3'h2;

   // Timing of the self-clearing soft reset.
   localparam int CLOCK_PERIOD_NS = 100;
   localparam int SOFT_RESET_NS = 10;
   localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS / CLOCK_PERIOD_NS < 1) ? 1 : SOFT_RESET_NS / CLOCK_PERIOD_NS;
   localparam int SRC_W = 4;

   // Soft reset sequencer states.
   typedef enum logic [1:0]
   {
      SR_IDLE = 2'h1,
      SR_ACTIVE = 2'h2
   } oprc_sr_state_t;

endpackage : oprc_pkg

// file: verilog/oprc_sync.sv
`timescale 1ns/1ns
module oprc_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Raw pins and their filtered copy.
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] level
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   // Three flops; the first feeds only the second so metastability stays contained.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stage1 <= INIT;
         stage2 <= INIT;
         stage3 <= INIT;
      end
      else
      begin
         stage1 <= pin;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // A lane only changes once the second and third stages agree, filtering one-cycle glitches.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         level <= INIT;
      else
         level <= (stage2 & stage3) | (level & (stage2 | stage3));
   end

endmodule : oprc_sync

// file: verilog/oprc_fifo.sv
`timescale 1ns/1ns
module oprc_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   // Clock, reset and synchronous flush.
   input wire logic clock,
   input wire logic rst_n,
   input wire logic flush,
   // Filling side.
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Draining side.
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready,
   // Fill level.
   output logic [$clog2(DEPTH+1)-1:0] level
);

   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
   localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [CNT_W-1:0] next_level;
   logic push;
   logic pop;

   // Handshakes on both sides; out_valid is honest because it follows the level.
   assign out_valid = (level != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Next fill level from the two handshakes.
   always_comb
   begin
      next_level = level;
      if (push && !pop)
         next_level = level + CNT_W'(1);
      else if (pop && !push)
         next_level = level - CNT_W'(1);
   end

   // Storage needs no reset; the pointers and the level define what is valid.
   always_ff @(posedge clock)
   begin
      if (push)
         mem[wr_ptr] <= in_data;
   end

   // Pointers, level and a registered ready so the filling side sees a clean flop.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level <= '0;
         in_ready <= 1'b1;
      end
      else if (flush)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level <= '0;
         in_ready <= 1'b1;
      end
      else
      begin
         if (push)
            wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + PTR_W'(1);
         if (pop)
            rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + PTR_W'(1);
         level <= next_level;
         in_ready <= (next_level != CNT_FULL);
      end
   end

endmodule : oprc_fifo

// file: verilog/oprc_top.sv
// Behaviour
// - Sleep when the sleep pin is high or the chip sleep bit is one.
// - Asleep, analog blocks are off and the pixel code bus floats.
// - Every register keeps its value through sleep.
// - Neither sleep source resets any register.
// - The register port keeps working while asleep.
// - Front-end and converter sleep bits each switch off only their stage.
// - Bus driven only with the drive bit high and enable pin low.
// - Enable controls touch only the drivers; calibration data keeps flowing.
// - Power-up reset loads defaults into every register.
// - Writing one to the reset bit resets the chip; bit then self-clears.
// - Reset pin low holds reset; release when high; pin pulled up externally here.
// - With floor clip on, codes below the black offset rise to it.
// - Floor clipping affects only the output; calibration tap stays unclipped.
// - With blank force on and preblank active, the bus shows the offset.
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ns
module oprc_top
   import oprc_pkg::*;
(
   // Clock and active-low reset pin.
   input wire logic clock,
   input wire logic arst_n,
   // Register port.
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [DATA_W-1:0] reg_rdata,
   // Asynchronous control pins.
   input wire logic sleep_request_pin,
   input wire logic output_enable_pin_n,
   input wire logic preblank_strobe,
   // Samples from the converter.
   input wire logic conv_valid,
   input wire logic [CODE_W-1:0] conv_code,
   output logic conv_ready,
   // Pixel code bus towards the image processor.
   output logic [CODE_W-1:0] pixel_code_bus,
   output logic pixel_code_oe_n,
   output logic pixel_valid,
   input wire logic pixel_ready,
   // Unclipped tap for the black-level calibration.
   output logic [CODE_W-1:0] cal_code,
   output logic cal_valid,
   // Power controls for the analog stages.
   output logic front_end_off,
   output logic converter_off
);

   ////////////////////////////////////////////////////////////////////////////
   // Reset release and soft reset.

   // Reset synchroniser flops and the soft reset sequencer state.
   logic rst_meta_n;
   logic rst_n;
   logic soft_reset;
   logic [SRC_W-1:0] soft_count;
   oprc_sr_state_t sr_state;
   logic reset_bit_write;

   // The pin reset asserts at once but releases through two flops to avoid a ragged release.
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_meta_n <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta_n <= 1'b1;
         rst_n <= rst_meta_n;
      end
   end

   // Only a one in the reset bit starts a soft reset; writing zero is harmless.
   assign reset_bit_write = reg_write && (reg_addr == ADDR_RESET) && reg_wdata[RST_BIT];

   // A write of one to the reset bit holds a synchronous chip reset for the self-clear time.
   // The figure is far below one clock period, so the pulse lasts one cycle.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sr_state <= SR_IDLE;
         soft_count <= '0;
         soft_reset <= 1'b0;
      end
      else
      begin
         unique case (sr_state)
            SR_IDLE:
            begin
               if (reset_bit_write)
               begin
                  sr_state <= SR_ACTIVE;
                  soft_count <= SRC_W'(SOFT_RESET_CYCLES - 1);
                  soft_reset <= 1'b1;
               end
            end
            SR_ACTIVE:
            begin
               if (soft_count == '0)
               begin
                  sr_state <= SR_IDLE;
                  soft_reset <= 1'b0;
               end
               else
                  soft_count <= soft_count - SRC_W'(1);
            end
            default:
            begin
               sr_state <= SR_IDLE;
               soft_reset <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation.

   // Filtered copies of the three asynchronous pins.
   logic [PIN_W-1:0] pins_level;
   logic sleep_pin;
   logic oe_pin_n;
   logic preblank;

   oprc_sync #(
      .WIDTH(PIN_W),
      .INIT(PIN_IDLE)
   ) u_pin_sync (
      .clock(clock),
      .rst_n(rst_n),
      .pin({preblank_strobe, output_enable_pin_n, sleep_request_pin}),
      .level(pins_level)
   );

   // Split the filtered lanes back into named levels.
   assign sleep_pin = pins_level[PIN_SLEEP];
   assign oe_pin_n = pins_level[PIN_OE_N];
   assign preblank = pins_level[PIN_PREBLANK];

   ////////////////////////////////////////////////////////////////////////////
   // Control and offset registers.

   // Control word, offset and the fields decoded from them.
   logic [CTL_W-1:0] control;
   logic [OFFSET_W-1:0] black_offset_code;
   logic chip_sleep_bit;
   logic front_end_sleep_bit;
   logic converter_sleep_bit;
   logic output_drive_bit;
   logic floor_clip_enable;
   logic blank_output_force;
   logic sleeping;

   assign chip_sleep_bit = control[CTL_CHIP_SLEEP];
   assign front_end_sleep_bit = control[CTL_FRONT_END_SLEEP];
   assign converter_sleep_bit = control[CTL_CONVERTER_SLEEP];
   assign output_drive_bit = control[CTL_OUTPUT_DRIVE];
   assign floor_clip_enable = control[CTL_FLOOR_CLIP];
   assign blank_output_force = control[CTL_BLANK_FORCE];

   // Either source puts the chip to sleep.
   assign sleeping = sleep_pin || chip_sleep_bit;

   // Only the resets load defaults; sleep never touches these, and writes land even while asleep.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         control <= CTL_RESET_VALUE;
      else if (soft_reset)
         control <= CTL_RESET_VALUE;
      else if (reg_write && (reg_addr == ADDR_CONTROL))
         control <= reg_wdata[CTL_W-1:0];
   end

   // Black offset register, with the same retention as the control word.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         black_offset_code <= OFFSET_RESET_VALUE;
      else if (soft_reset)
         black_offset_code <= OFFSET_RESET_VALUE;
      else if (reg_write && (reg_addr == ADDR_OFFSET))
         black_offset_code <= reg_wdata[OFFSET_W-1:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sample buffer.

   // Draining side of the buffer as seen by the output path.
   logic fifo_valid;
   logic [CODE_W-1:0] fifo_code;
   logic [LEVEL_W-1:0] fifo_level;
   logic pop;

   // The buffer stalls the converter through conv_ready when the processor holds off.
   oprc_fifo #(
      .WIDTH(CODE_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .rst_n(rst_n),
      .flush(soft_reset),
      .in_valid(conv_valid),
      .in_data(conv_code),
      .in_ready(conv_ready),
      .out_valid(fifo_valid),
      .out_data(fifo_code),
      .out_ready(pixel_ready),
      .level(fifo_level)
   );

   // A word leaves the buffer only when the processor takes it.
   assign pop = fifo_valid && pixel_ready;

   ////////////////////////////////////////////////////////////////////////////
   // Output code path.

   // Widened offset and the code chosen for the next output word.
   logic [CODE_W-1:0] offset_wide;
   logic [CODE_W-1:0] next_code;
   logic force_now;

   // The offset is unsigned; widening with zeros keeps the compare honest.
   assign offset_wide = {{(CODE_W - OFFSET_W){1'b0}}, black_offset_code};
   assign force_now = blank_output_force && preblank;

   // Forcing during preblank wins over clipping; the word popped then is dropped as it carries no image.
   always_comb
   begin
      next_code = fifo_code;
      if (force_now)
         next_code = offset_wide;
      else if (floor_clip_enable && (fifo_code < offset_wide))
         next_code = offset_wide;
   end

   // The output register updates on this clock only, so forced and clipped codes share one timing.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pixel_code_bus <= '0;
         pixel_valid <= 1'b0;
      end
      else if (soft_reset)
      begin
         pixel_code_bus <= '0;
         pixel_valid <= 1'b0;
      end
      else
      begin
         if (pop || force_now)
            pixel_code_bus <= next_code;
         pixel_valid <= pop || force_now;
      end
   end

   // The calibration tap sees raw samples and keeps running whether or not the bus floats.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cal_code <= '0;
         cal_valid <= 1'b0;
      end
      else if (soft_reset)
      begin
         cal_code <= '0;
         cal_valid <= 1'b0;
      end
      else
      begin
         if (pop)
            cal_code <= fifo_code;
         cal_valid <= pop;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Driver enable and power controls.

   // Drivers need the drive bit, the enable pin low and no sleep; nothing else depends on them.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         pixel_code_oe_n <= 1'b1;
      else
         pixel_code_oe_n <= !(output_drive_bit && !oe_pin_n && !sleeping);
   end

   // Chip sleep switches off both stages; each test bit switches off only its own.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         front_end_off <= 1'b0;
         converter_off <= 1'b0;
      end
      else
      begin
         front_end_off <= sleeping || front_end_sleep_bit;
         converter_off <= sleeping || converter_sleep_bit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register read port.

   // Snapshot of live state offered to software.
   logic [DATA_W-1:0] status_word;

   // Live state for software, including the buffer level.
   always_comb
   begin
      status_word = '0;
      status_word[STS_SLEEPING] = sleeping;
      status_word[STS_BUS_DRIVEN] = !pixel_code_oe_n;
      status_word[STS_FRONT_END_OFF] = front_end_off;
      status_word[STS_CONVERTER_OFF] = converter_off;
      status_word[STS_LEVEL_LSB +: LEVEL_W] = fifo_level;
   end

   // Read data stands for exactly the cycle after the strobe; unmapped addresses read zero.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= '0;
      else if (reg_read)
      begin
         unique case (reg_addr)
            ADDR_CONTROL: reg_rdata <= {{(DATA_W - CTL_W){1'b0}}, control};
            ADDR_OFFSET: reg_rdata <= {{(DATA_W - OFFSET_W){1'b0}}, black_offset_code};
            ADDR_RESET: reg_rdata <= {{(DATA_W - 1){1'b0}}, soft_reset};
            ADDR_STATUS: reg_rdata <= status_word;
            default: reg_rdata <= '0;
         endcase
      end
      else
         reg_rdata <= '0;
   end

endmodule : oprc_top

// file: dv/oprc_chk.sv
`timescale 1ns/1ns
module oprc_chk
   import oprc_pkg::*;
(
   // Clock and reset pin.
   input wire logic clock,
   input wire logic arst_n,
   // Register port.
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [DATA_W-1:0] reg_rdata,
   // Pins.
   input wire logic sleep_request_pin,
   input wire logic output_enable_pin_n,
   input wire logic preblank_strobe,
   // Data path and power outputs.
   input wire logic conv_ready,
   input wire logic pixel_ready,
   input wire logic [CODE_W-1:0] pixel_code_bus,
   input wire logic pixel_code_oe_n,
   input wire logic pixel_valid,
   input wire logic [CODE_W-1:0] cal_code,
   input wire logic cal_valid,
   input wire logic front_end_off,
   input wire logic converter_off
);
   // Everything here lives in the one clock domain.
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);

   a_rdata_idle_zero: assert property (!$past(reg_read) |-> reg_rdata == '0)
      else $error("read data seen outside its answer cycle");
   a_reset_out_safe: assert property ($rose(arst_n) |-> pixel_code_oe_n && conv_ready && !pixel_valid && !cal_valid)
      else $error("outputs not at reset values while leaving reset");
   // Seven samples of a steady pin cover the filter and the output flop.
   a_sleep_floats_bus: assert property (sleep_request_pin [*7] |-> pixel_code_oe_n && front_end_off && converter_off)
      else $error("sleep pin did not float the bus or power down");
   a_enable_pin_floats: assert property (output_enable_pin_n [*7] |-> pixel_code_oe_n)
      else $error("bus driven while the enable pin is high");
   a_cal_after_ready: assert property (cal_valid |-> $past(pixel_ready))
      else $error("calibration word without a pop");
   a_cal_with_pixel: assert property (cal_valid |-> pixel_valid)
      else $error("calibration word without an output word");
   // Forcing may put a lower value on the bus, so only quiet blanking counts.
   a_clip_only_raises: assert property ((!preblank_strobe) [*8] ##0 cal_valid |-> pixel_code_bus >= cal_code)
      else $error("output code below the unclipped sample");
   a_bus_holds_idle: assert property (!pixel_valid && !$past(reg_write) && !$past(reg_write, 2) |-> $stable(pixel_code_bus))
      else $error("pixel code changed without a transfer");

   c_forced: cover property (preblank_strobe && pixel_valid);
   c_full: cover property (!conv_ready);
   c_clipped: cover property (cal_valid && pixel_code_bus != cal_code);
endmodule : oprc_chk

bind oprc_top oprc_chk u_chk (.clock(clock), .arst_n(arst_n), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .sleep_request_pin(sleep_request_pin), .output_enable_pin_n(output_enable_pin_n),
   .preblank_strobe(preblank_strobe), .conv_ready(conv_ready), .pixel_ready(pixel_ready),
   .pixel_code_bus(pixel_code_bus), .pixel_code_oe_n(pixel_code_oe_n), .pixel_valid(pixel_valid),
   .cal_code(cal_code), .cal_valid(cal_valid), .front_end_off(front_end_off), .converter_off(converter_off));

// file: dv/oprc_sink.sv
`timescale 1ns/1ns
module oprc_sink
   import oprc_pkg::*;
(
   // Clock and stall request from the bench.
   input wire logic clock,
   input wire logic stall,
   // Pixel code bus.
   input wire logic [CODE_W-1:0] pixel_code_bus,
   input wire logic pixel_code_oe_n,
   input wire logic pixel_valid,
   output logic pixel_ready
);
   logic [CODE_W-1:0] seen [$];

   // A stalled processor backs the buffer up, as a slow one would.
   always_comb pixel_ready = !stall;

   // A floating bus carries nothing, so only driven words are taken.
   // Sampling mid-cycle keeps the queue settled before the bench looks at it on a rising edge.
   always @(negedge clock)
      if (pixel_valid && !pixel_code_oe_n)
         seen.push_back(pixel_code_bus);
endmodule : oprc_sink

// file: dv/tb.sv
`timescale 1ns/1ns
module tb
   import oprc_pkg::*;
   ;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [DATA_W-1:0] reg_rdata;
   logic sleep_request_pin = 1'b0;
   logic output_enable_pin_n = 1'b0;
   logic preblank_strobe = 1'b0;
   logic conv_valid = 1'b0;
   logic [CODE_W-1:0] conv_code = '0;
   logic conv_ready, pixel_code_oe_n, pixel_valid, pixel_ready, cal_valid, front_end_off, converter_off;
   logic [CODE_W-1:0] pixel_code_bus, cal_code;
   logic stall = 1'b0;
   logic [CODE_W-1:0] cal_q [$];
   int num_errors = 0;
   int n_tests = 0;

   oprc_top uut (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .sleep_request_pin(sleep_request_pin),
      .output_enable_pin_n(output_enable_pin_n), .preblank_strobe(preblank_strobe), .conv_valid(conv_valid),
      .conv_code(conv_code), .conv_ready(conv_ready), .pixel_code_bus(pixel_code_bus),
      .pixel_code_oe_n(pixel_code_oe_n), .pixel_valid(pixel_valid), .pixel_ready(pixel_ready),
      .cal_code(cal_code), .cal_valid(cal_valid), .front_end_off(front_end_off), .converter_off(converter_off));
   oprc_sink sink (.clock(clock), .stall(stall), .pixel_code_bus(pixel_code_bus),
      .pixel_code_oe_n(pixel_code_oe_n), .pixel_valid(pixel_valid), .pixel_ready(pixel_ready));

   // Clock at 10 MHz.
   always #50 clock = !clock;

   // The calibration tap is collected mid-cycle, whether the bus floats or not, in step with the sink.
   always @(negedge clock)
      if (cal_valid)
         cal_q.push_back(cal_code);

   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Strobes get a gap cycle so no strobe is assigned twice in one step.
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      @(posedge clock);
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 chk(reg_rdata, exp);
      @(posedge clock);
   endtask : rd

   // Output enable and both power outputs, looked at once settled.
   task automatic pins(input int n, input logic [2:0] exp);
      repeat (n) @(posedge clock);
      #1 chk(32'({pixel_code_oe_n, front_end_off, converter_off}), 32'(exp));
      @(posedge clock);
   endtask : pins

   task automatic push(input logic [CODE_W-1:0] c);
      int i;
      conv_code <= c;
      conv_valid <= 1'b1;
      #1;
      for (i = 0; i < 50 && conv_ready !== 1'b1; i++)
         @(posedge clock) #1;
      if (i == 50)
      begin
         num_errors++;
         end_sim();
      end
      @(posedge clock);
      conv_valid <= 1'b0;
      @(posedge clock);
   endtask : push

   task automatic drain(input int n);
      int i;
      for (i = 0; i < 100 && cal_q.size() < n; i++)
         @(posedge clock);
      if (i == 100)
      begin
         num_errors++;
         end_sim();
      end
   endtask : drain

   task automatic take(input logic [CODE_W-1:0] p, input logic [CODE_W-1:0] c);
      drain(1);
      chk(32'(sink.seen.pop_front()), 32'(p));
      chk(32'(cal_q.pop_front()), 32'(c));
   endtask : take

   task automatic do_reset();
      arst_n <= 1'b0;
      repeat (16) @(posedge clock);
      #1 chk(32'({pixel_code_oe_n, conv_ready, pixel_valid}), 32'h6);
      @(posedge clock);
      arst_n <= 1'b1;
      repeat (3) @(posedge clock);
   endtask : do_reset

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_defaults();
      rd(ADDR_CONTROL, 32'h38);
      rd(ADDR_OFFSET, 32'h0);
      wr(ADDR_STATUS, 32'hff);
      rd(ADDR_STATUS, 32'h2);
      rd(8'h10, 32'h0);
      $display("defaults done");
   endtask : t_defaults

   task automatic t_clip();
      wr(ADDR_OFFSET, 32'hff);
      push(12'h0fe);
      take(12'h0ff, 12'h0fe);
      push(12'h100);
      take(12'h100, 12'h100);
      wr(ADDR_OFFSET, 32'h10);
      push(12'h010);
      take(12'h010, 12'h010);
      wr(ADDR_CONTROL, 32'h28);
      push(12'h003);
      take(12'h003, 12'h003);
      wr(ADDR_CONTROL, 32'h38);
      $display("clip done");
   endtask : t_clip

   // The buffer is filled against a stalled processor, then drained in order.
   task automatic t_fill();
      stall <= 1'b1;
      for (int i = 0; i < FIFO_DEPTH; i++)
         push(12'(12'h100 + i));
      chk(32'(conv_ready), 32'h0);
      rd(ADDR_STATUS, 32'h802);
      stall <= 1'b0;
      for (int i = 0; i < FIFO_DEPTH; i++)
         take(12'(12'h100 + i), 12'(12'h100 + i));
      rd(ADDR_STATUS, 32'h2);
      $display("fill done");
   endtask : t_fill

   task automatic t_sleep();
      sleep_request_pin <= 1'b1;
      pins(8, 3'h7);
      rd(ADDR_STATUS, 32'hd);
      rd(ADDR_OFFSET, 32'h10);
      sleep_request_pin <= 1'b0;
      pins(8, 3'h0);
      sleep_request_pin <= 1'b1;
      @(posedge clock);
      sleep_request_pin <= 1'b0;
      pins(8, 3'h0);
      wr(ADDR_CONTROL, 32'h39);
      pins(2, 3'h7);
      rd(ADDR_OFFSET, 32'h10);
      wr(ADDR_CONTROL, 32'h3a);
      pins(2, 3'h2);
      wr(ADDR_CONTROL, 32'h3c);
      pins(2, 3'h1);
      wr(ADDR_CONTROL, 32'h38);
      $display("sleep done");
   endtask : t_sleep

   task automatic t_enable();
      wr(ADDR_CONTROL, 32'h30);
      pins(2, 3'h4);
      push(12'h020);
      drain(1);
      chk(32'(cal_q.pop_front()), 32'h20);
      chk(32'(sink.seen.size()), 32'h0);
      wr(ADDR_CONTROL, 32'h38);
      output_enable_pin_n <= 1'b1;
      pins(8, 3'h4);
      output_enable_pin_n <= 1'b0;
      pins(8, 3'h0);
      $display("enable done");
   endtask : t_enable

   task automatic t_force();
      preblank_strobe <= 1'b1;
      repeat (7) @(posedge clock);
      #1 chk(32'({pixel_valid, pixel_code_bus}), 32'h1010);
      @(posedge clock);
      preblank_strobe <= 1'b0;
      repeat (8) @(posedge clock);
      chk(32'(sink.seen[0]), 32'h10);
      sink.seen.delete();
      // With forcing off, blanking must leave the bus idle.
      wr(ADDR_CONTROL, 32'h18);
      preblank_strobe <= 1'b1;
      repeat (7) @(posedge clock);
      #1 chk(32'({pixel_valid, pixel_code_bus}), 32'h10);
      @(posedge clock);
      preblank_strobe <= 1'b0;
      repeat (8) @(posedge clock);
      wr(ADDR_CONTROL, 32'h38);
      $display("force done");
   endtask : t_force

   task automatic t_soft();
      wr(ADDR_OFFSET, 32'h33);
      wr(ADDR_CONTROL, 32'h0);
      wr(ADDR_RESET, 32'h1);
      rd(ADDR_CONTROL, 32'h38);
      rd(ADDR_OFFSET, 32'h0);
      rd(ADDR_RESET, 32'h0);
      wr(ADDR_OFFSET, 32'h44);
      do_reset();
      rd(ADDR_OFFSET, 32'h0);
      $display("resets done");
   endtask : t_soft

   initial
   begin
      do_reset();
      t_defaults();
      t_clip();
      t_fill();
      t_sleep();
      t_enable();
      t_force();
      t_soft();
      end_sim();
   end
endmodule : tb
